// *** css_pkg.sv ***
// Shared constants, register map and carrier types of the cell slot scheduler.
// Functional notes
// - A schedule request carries a 16-bit connection identifier and a target slot.
// - Scan the occupancy bitmap from the target and pick the first free slot.
// - On reaching the last bitmap position, wrap to the first and keep searching.
// - Mark the chosen slot occupied and store the identifier in its table entry.
// - Requests run alongside the processor, which never stalls while they run.
// - Busy flag, state register bit 5, stays high while an operation runs.
// - On completion the scheduled address register holds the slot actually chosen.
// - Back-pressure mode queues an unassigned cell when a serviced slot was free.
// - External mode paces cells by a tick from either interval timer.
// - External mode sends only user cells; no idle cells when nothing is pending.
// - Section size field bits 13:12 selects 2048, 4096, 8192 or 16384 slots.
// - No free slot found sets error bit 15 of the configuration register.
// - A search should find a free slot and write the identifier quickly.
package css_pkg;

    // Sizes.
    localparam int SLOTS_DEF = 16384;
    localparam int WORD_W    = 32;
    localparam int CID_W     = 16;
    localparam int SLOT_W    = 14;
    localparam int SEC_BASE  = 2048;
    localparam int ADDR_W    = 8;
    localparam int SEARCH_CYCLES_TYP = 12;

    // Register offsets.
    localparam logic [7:0] OFF_CFG      = 8'h00;
    localparam logic [7:0] OFF_STATE    = 8'h04;
    localparam logic [7:0] OFF_SCHED_AD = 8'h08;
    localparam logic [7:0] OFF_SCHED_CM = 8'h0c;
    localparam logic [7:0] OFF_SERV_CM  = 8'h10;
    localparam logic [7:0] OFF_SERV_DAT = 8'h14;
    localparam logic [7:0] OFF_INT_STAT = 8'h18;
    localparam logic [7:0] OFF_INT_MASK = 8'h1c;

    // Field positions.
    localparam int CFG_EXT_BIT   = 0;
    localparam int CFG_TSEL_BIT  = 1;
    localparam int CFG_SIZE_LO   = 12;
    localparam int CFG_ERR_BIT   = 15;
    localparam int ST_ASSIGN_BIT = 4;
    localparam int ST_BUSY_BIT   = 5;
    localparam int CMD_CID_LO    = 16;
    localparam int INT_SCHED     = 0;
    localparam int INT_ERR       = 1;
    localparam int INT_SERV      = 2;
    localparam int INT_W         = 3;

    // Reset values.
    localparam logic [1:0]       SIZE_RST = 2'h3;
    localparam logic [INT_W-1:0] MASK_RST = 3'h0;

    typedef enum {ST_IDLE, ST_SCAN, ST_WRITE, ST_SERVE} css_state_t;

    typedef struct packed {
        logic [CID_W-1:0]  cid;
        logic [SLOT_W-1:0] target;
    } css_req_t;

    typedef struct packed {
        logic             unassigned;
        logic [CID_W-1:0] cid;
    } css_cell_t;

endpackage

// *** css_sync.sv ***
// Three-stage pin synchroniser with agreement filter and rising-edge pulse.
`timescale 1ns/10ps
module css_sync import css_pkg::*; #(
    parameter int N = 2
) (
    // Clock and reset.
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Pins and filtered result.
    input  wire logic [N-1:0] pin_in,
    output logic      [N-1:0] rise_pulse
);
    logic [N-1:0] s1_r;
    logic [N-1:0] s2_r;
    logic [N-1:0] s3_r;
    logic [N-1:0] lvl_r;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            // Shift the pin through three stages; accept a level once the last two agree.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_r[g]  <= 1'b0;
                    s2_r[g]  <= 1'b0;
                    s3_r[g]  <= 1'b0;
                    lvl_r[g] <= 1'b0;
                end else begin
                    s1_r[g] <= pin_in[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g]) begin
                        lvl_r[g] <= s3_r[g];
                    end
                end
            end
            // One pulse when the accepted level rises.
            assign rise_pulse[g] = s2_r[g] & s3_r[g] & ~lvl_r[g];
        end
    endgenerate
endmodule

// *** css_pacer.sv ***
// Transmit pacing: holds one cell and presents it by back pressure or timer tick.
`timescale 1ns/10ps
module css_pacer import css_pkg::*; (
    // Clock and reset.
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Mode and tick.
    input  wire logic             ext_mode,
    input  wire logic             tick,
    // Service result.
    input  wire logic             serv_done,
    input  wire logic             serv_assigned,
    input  wire logic [CID_W-1:0] serv_cid,
    output logic                  pace_ready,
    // Cell port.
    output logic                  cell_valid,
    output css_cell_t             cell_out,
    input  wire logic             cell_ready
);
    logic pend_r;
    logic credit_r;

    // A service result is only accepted while no cell is held.
    assign pace_ready = ~pend_r;
    // External mode waits for a tick; back-pressure mode presents at once.
    assign cell_valid = pend_r & (~ext_mode | credit_r);

    // Capture a cell per service result; free slots become unassigned cells only in back-pressure mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r   <= 1'b0;
            cell_out <= '0;
        end else if (cell_valid && cell_ready) begin
            pend_r <= 1'b0;
        end else if (serv_done && !pend_r) begin
            if (serv_assigned) begin
                pend_r   <= 1'b1;
                cell_out <= '{unassigned: 1'b0, cid: serv_cid};
            end else if (!ext_mode) begin
                pend_r   <= 1'b1;
                cell_out <= '{unassigned: 1'b1, cid: '0};
            end
        end
    end

    // One transmit opportunity is banked per tick; it is spent by a handshake.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            credit_r <= 1'b0;
        end else if (tick) begin
            credit_r <= 1'b1;
        end else if (cell_valid && cell_ready) begin
            credit_r <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_unassigned_bp;
        serv_done && !pend_r && !serv_assigned && !ext_mode |=> cell_valid && cell_out.unassigned;
    endproperty
    a_unassigned_bp: assert property (p_unassigned_bp) else $error("free slot gave no unassigned cell");

    property p_no_idle;
        ext_mode && $stable(ext_mode) |-> !(cell_valid && cell_out.unassigned);
    endproperty
    a_no_idle: assert property (p_no_idle) else $error("idle cell sent in external mode");

    property p_tick_gate;
        ext_mode && cell_valid && cell_ready && !tick |=> !credit_r;
    endproperty
    a_tick_gate: assert property (p_tick_gate) else $error("tick credit not spent by a handshake");

    c_unassigned: cover property (cell_valid && cell_ready && cell_out.unassigned);
endmodule

// *** css_cell_slot_scheduler.sv ***
// Cell slot scheduler top: APB registers, bitmap search, connection table and pacing.
`timescale 1ns/10ps
module css_cell_slot_scheduler import css_pkg::*; #(
    parameter int SLOTS = SLOTS_DEF
) (
    // Clock and reset.
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Interval timer pins.
    input  wire logic              interval_timer_zero,
    input  wire logic              interval_timer_one,
    // Cell port.
    output logic                   cell_valid,
    output css_cell_t              cell_out,
    input  wire logic              cell_ready,
    // Interrupt.
    output logic                   irq
);
    localparam int NW   = SLOTS / WORD_W;
    localparam int WIX  = $clog2(NW);
    localparam int OFFW = $clog2(WORD_W);
    localparam int SW   = WIX + OFFW;

    css_state_t         state_r;
    logic [WORD_W-1:0]  bmp_r [NW];
    logic [CID_W-1:0]   tab_r [SLOTS];
    logic [WIX-1:0]     word_r;
    logic [OFFW-1:0]    off_r;
    logic [WIX:0]       cnt_r;
    logic [CID_W-1:0]   cid_r;
    logic [SW-1:0]      slot_r;
    logic [SW-1:0]      sched_addr_r;
    logic [CID_W-1:0]   serv_cid_r;
    logic               assigned_r;
    logic               ext_mode_r;
    logic               tsel_r;
    logic [1:0]         size_r;
    logic               err_r;
    logic [INT_W-1:0]   int_stat_r;
    logic [INT_W-1:0]   int_mask_r;
    logic [31:0]        prdata_r;
    logic [1:0]         tick_rise;
    logic               pace_ready;
    logic               serv_done_r;

    // Words in the active section, capped by the built bitmap size.
    function automatic logic [WIX:0] sec_words(input logic [1:0] sz);
        int sec;
        sec = SEC_BASE << sz;
        if (sec > SLOTS) begin
            sec = SLOTS;
        end
        return (WIX+1)'(sec / WORD_W);
    endfunction

    // Lowest set bit of a word: bit OFFW tells whether any bit is set.
    function automatic logic [OFFW:0] first_set(input logic [WORD_W-1:0] v);
        logic [OFFW:0] r;
        r = '0;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, OFFW'(i)};
            end
        end
        return r;
    endfunction

    // Bus decode; the slave never inserts wait states, so the core is never held up.
    logic access;
    logic wr_en;
    logic setup;
    assign access  = psel & penable;
    assign wr_en   = access & pwrite;
    assign setup   = psel & ~penable;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = prdata_r;

    logic             busy;
    logic [WIX:0]     nw_act;
    logic             sched_wr;
    logic             serv_wr;
    logic             sched_go;
    logic             serv_go;
    css_req_t         req;
    logic [SW-1:0]    tgt_act;
    assign busy     = (state_r != ST_IDLE);
    assign nw_act   = sec_words(size_r);
    assign sched_wr = wr_en && paddr == OFF_SCHED_CM;
    assign serv_wr  = wr_en && paddr == OFF_SERV_CM;
    assign req      = '{cid: pwdata[CMD_CID_LO +: CID_W], target: pwdata[SLOT_W-1:0]};
    assign tgt_act  = SW'(req.target) & SW'((nw_act * WORD_W) - 1);
    // A new request is taken only while idle; one arriving mid-operation is dropped.
    assign sched_go = sched_wr && !busy;
    assign serv_go  = serv_wr && !busy && pace_ready;

    // Search window: tail of the start word first, whole words next, head of the start word last.
    logic [WORD_W-1:0] hi_mask;
    logic [WORD_W-1:0] win_mask;
    logic [OFFW:0]     hit;
    logic              found;
    logic              last_pass;
    assign hi_mask   = {WORD_W{1'b1}} << off_r;
    assign last_pass = (cnt_r == nw_act);
    assign win_mask  = (cnt_r == '0) ? hi_mask : (last_pass ? ~hi_mask : {WORD_W{1'b1}});
    assign hit       = first_set(~bmp_r[word_r] & win_mask);
    assign found     = hit[OFFW];

    // Operation sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            word_r  <= '0;
            off_r   <= '0;
            cnt_r   <= '0;
            cid_r   <= '0;
            slot_r  <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (sched_go) begin
                        word_r  <= tgt_act[SW-1:OFFW];
                        off_r   <= tgt_act[OFFW-1:0];
                        cnt_r   <= '0;
                        cid_r   <= req.cid;
                        state_r <= ST_SCAN;
                    end else if (serv_go) begin
                        slot_r  <= SW'(pwdata[SLOT_W-1:0]) & SW'((nw_act * WORD_W) - 1);
                        state_r <= ST_SERVE;
                    end
                end
                ST_SCAN: begin
                    if (found) begin
                        slot_r  <= {word_r, hit[OFFW-1:0]};
                        state_r <= ST_WRITE;
                    end else if (last_pass) begin
                        state_r <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                        if (word_r == WIX'(nw_act - 1'b1)) begin
                            word_r <= '0;
                        end else begin
                            word_r <= word_r + 1'b1;
                        end
                    end
                end
                ST_WRITE: state_r <= ST_IDLE;
                ST_SERVE: state_r <= ST_IDLE;
                default:  state_r <= ST_IDLE;
            endcase
        end
    end

    // Occupancy bitmap: set on schedule, cleared on service.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NW; i++) begin
                bmp_r[i] <= '0;
            end
        end else if (state_r == ST_WRITE) begin
            bmp_r[slot_r[SW-1:OFFW]][slot_r[OFFW-1:0]] <= 1'b1;
        end else if (state_r == ST_SERVE) begin
            bmp_r[slot_r[SW-1:OFFW]][slot_r[OFFW-1:0]] <= 1'b0;
        end
    end

    // Connection table holds data only, so it carries no reset.
    always_ff @(posedge pclk) begin
        if (state_r == ST_WRITE) begin
            tab_r[slot_r] <= cid_r;
        end
    end

    // Results: chosen slot, serviced entry and its assigned flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sched_addr_r <= '0;
            serv_cid_r   <= '0;
            assigned_r   <= 1'b0;
            serv_done_r  <= 1'b0;
        end else begin
            serv_done_r <= (state_r == ST_SERVE);
            if (state_r == ST_WRITE) begin
                sched_addr_r <= slot_r;
            end
            if (state_r == ST_SERVE) begin
                serv_cid_r <= tab_r[slot_r];
                assigned_r <= bmp_r[slot_r[SW-1:OFFW]][slot_r[OFFW-1:0]];
            end
        end
    end

    // Configuration register; the full-bitmap error is cleared by writing one, and a new error wins.
    logic err_set;
    assign err_set = (state_r == ST_SCAN) && !found && last_pass;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_mode_r <= 1'b0;
            tsel_r     <= 1'b0;
            size_r     <= SIZE_RST;
            err_r      <= 1'b0;
        end else begin
            if (wr_en && paddr == OFF_CFG) begin
                ext_mode_r <= pwdata[CFG_EXT_BIT];
                tsel_r     <= pwdata[CFG_TSEL_BIT];
                size_r     <= pwdata[CFG_SIZE_LO +: 2];
            end
            if (err_set) begin
                err_r <= 1'b1;
            end else if (wr_en && paddr == OFF_CFG && pwdata[CFG_ERR_BIT]) begin
                err_r <= 1'b0;
            end
        end
    end

    // Interrupt status is read-clear; only bits already returned are cleared, so late events survive.
    logic [INT_W-1:0] int_set;
    logic [INT_W-1:0] int_clr;
    assign int_set = {serv_done_r, err_set, state_r == ST_WRITE};
    assign int_clr = (access && !pwrite && paddr == OFF_INT_STAT) ? prdata_r[INT_W-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_r <= '0;
            int_mask_r <= MASK_RST;
        end else begin
            int_stat_r <= (int_stat_r & ~int_clr) | int_set;
            if (wr_en && paddr == OFF_INT_MASK) begin
                int_mask_r <= pwdata[INT_W-1:0];
            end
        end
    end
    assign irq = |(int_stat_r & int_mask_r);

    // Read data is captured in the setup phase and returned in the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (setup && !pwrite) begin
            prdata_r <= '0;
            case (paddr)
                OFF_CFG: begin
                    prdata_r[CFG_EXT_BIT]       <= ext_mode_r;
                    prdata_r[CFG_TSEL_BIT]      <= tsel_r;
                    prdata_r[CFG_SIZE_LO +: 2]  <= size_r;
                    prdata_r[CFG_ERR_BIT]       <= err_r;
                end
                OFF_STATE: begin
                    prdata_r[ST_BUSY_BIT]   <= busy;
                    prdata_r[ST_ASSIGN_BIT] <= assigned_r;
                end
                OFF_SCHED_AD: prdata_r[SW-1:0]      <= sched_addr_r;
                OFF_SERV_DAT: prdata_r[CID_W-1:0]   <= serv_cid_r;
                OFF_INT_STAT: prdata_r[INT_W-1:0]   <= int_stat_r;
                OFF_INT_MASK: prdata_r[INT_W-1:0]   <= int_mask_r;
                default:      prdata_r              <= '0;
            endcase
        end
    end

    // Timer pins are foreign to this clock; either one may pace external mode.
    css_sync #(.N(2)) u_sync (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin_in     ({interval_timer_one, interval_timer_zero}),
        .rise_pulse (tick_rise)
    );

    css_pacer u_pacer (
        .pclk          (pclk),
        .presetn       (presetn),
        .ext_mode      (ext_mode_r),
        .tick          (tick_rise[tsel_r]),
        .serv_done     (serv_done_r),
        .serv_assigned (assigned_r),
        .serv_cid      (serv_cid_r),
        .pace_ready    (pace_ready),
        .cell_valid    (cell_valid),
        .cell_out      (cell_out),
        .cell_ready    (cell_ready)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_busy_hold;
        sched_go |=> busy [*2];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy not held after request");

    property p_start;
        sched_go |=> state_r == ST_SCAN && word_r == $past(tgt_act[SW-1:OFFW]) && cnt_r == 0;
    endproperty
    a_start: assert property (p_start) else $error("scan did not start at target");

    property p_wrap;
        state_r == ST_SCAN && !found && !last_pass && word_r == WIX'(nw_act - 1'b1) |=> word_r == 0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("scan did not wrap to slot zero");

    property p_mark;
        state_r == ST_WRITE |=> bmp_r[$past(slot_r[SW-1:OFFW])][$past(slot_r[OFFW-1:0])]
                                && tab_r[$past(slot_r)] == $past(cid_r);
    endproperty
    a_mark: assert property (p_mark) else $error("slot not marked or identifier not stored");

    property p_addr;
        state_r == ST_WRITE |=> sched_addr_r == $past(slot_r) && !busy;
    endproperty
    a_addr: assert property (p_addr) else $error("scheduled address not loaded on completion");

    property p_err;
        state_r == ST_SCAN && !found && last_pass |=> err_r && state_r == ST_IDLE;
    endproperty
    a_err: assert property (p_err) else $error("full bitmap did not raise error");

    property p_one_op;
        busy && sched_wr |=> $stable(cid_r);
    endproperty
    a_one_op: assert property (p_one_op) else $error("request accepted while busy");

    property p_size;
        (SEC_BASE << size_r) >= SLOTS || nw_act * WORD_W == (SEC_BASE << size_r);
    endproperty
    a_size: assert property (p_size) else $error("section size decode wrong");

    property p_nostall;
        access |-> pready;
    endproperty
    a_nostall: assert property (p_nostall) else $error("bus stalled");

    c_wrap:  cover property (state_r == ST_SCAN && word_r == 0 && cnt_r != 0);
    c_write: cover property (state_r == ST_WRITE && slot_r != $past(tgt_act, 2));
    c_err:   cover property (err_set);
    c_serve: cover property (serv_done_r && assigned_r);
endmodule

// *** css_cell_sink.sv ***
// Cell port sink that stalls every offered cell for a few cycles before taking it.
`timescale 1ns/10ps
module css_cell_sink import css_pkg::*; (
    // Clock and reset.
    input  wire logic      pclk,
    input  wire logic      presetn,
    // Cell port.
    input  wire logic      cell_valid,
    input  wire css_cell_t cell_out,
    output logic           cell_ready,
    // Capture.
    output int             n_cells,
    output css_cell_t      last_cell
);
    logic [2:0] wait_r;

    // Ready rises only after the cell has waited, so the scheduler must hold it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= 3'h0;
            cell_ready <= 1'b0;
            n_cells <= 0;
            last_cell <= '0;
        end else if (cell_valid && cell_ready) begin
            n_cells <= n_cells + 1;
            last_cell <= cell_out;
            cell_ready <= 1'b0;
            wait_r <= 3'h0;
        end else if (cell_valid) begin
            wait_r <= wait_r + 3'h1;
            cell_ready <= (wait_r == 3'h3);
        end
    end
endmodule

// *** tb.sv ***
// Self-checking testbench of the cell slot scheduler over APB.
`timescale 1ns/10ps
module tb import css_pkg::*; ();
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic              cell_valid, cell_ready, irq, tz, to, qerr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, q;
    css_cell_t         cell_out, last_cell;
    int                n_cells, ncell0, errors, n_compared, i, npoll;

    css_cell_slot_scheduler #(.SLOTS(2048)) i_css_cell_slot_scheduler (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .interval_timer_zero(tz), .interval_timer_one(to),
        .cell_valid(cell_valid), .cell_out(cell_out), .cell_ready(cell_ready), .irq(irq));
    css_cell_sink i_css_cell_sink (.pclk(pclk), .presetn(presetn), .cell_valid(cell_valid),
        .cell_out(cell_out), .cell_ready(cell_ready), .n_cells(n_cells), .last_cell(last_cell));

    // Clock at 40 MHz.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Compares a result word.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One APB transfer with an idle cycle after it; read data lands in q.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        qerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    // Polls the state register until the busy flag clears; q then holds that state.
    task automatic wait_idle();
        int k;
        k = 0;
        do begin
            apb(1'b0, OFF_STATE, 32'h0);
            k++;
        end while (q[ST_BUSY_BIT] !== 1'b0 && k < 200);
        npoll = k;
        chk({31'h0, q[ST_BUSY_BIT]}, 32'h0);
    endtask

    task automatic sched(input logic [15:0] cid, input logic [13:0] tgt, input logic [13:0] e);
        apb(1'b1, OFF_SCHED_CM, {cid, 2'h0, tgt});
        wait_idle();
        rd_chk(OFF_SCHED_AD, {18'h0, e});
    endtask

    task automatic serv(input logic [13:0] slot, input logic asg, input logic [15:0] cid);
        apb(1'b1, OFF_SERV_CM, {18'h0, slot});
        wait_idle();
        chk(q & 32'h10, {27'h0, asg, 4'h0});
        if (asg) rd_chk(OFF_SERV_DAT, {16'h0, cid});
    endtask

    // Waits for the sink to take one cell and compares it, or checks that none came.
    task automatic cell_chk(input int n, input logic [16:0] e);
        int k;
        for (k = 0; k < 60 && n_cells == ncell0; k++) @(posedge pclk);
        chk(32'(n_cells - ncell0), 32'(n));
        if (n > 0) chk({15'h0, last_cell}, {15'h0, e});
        ncell0 = n_cells;
    endtask

    task automatic pulse(input logic one);
        if (one) to <= 1'b1;
        else tz <= 1'b1;
        repeat (6) @(posedge pclk);
        tz <= 1'b0;
        to <= 1'b0;
    endtask

    // Cuts a hang short.
    initial begin
        #2ms;
        errors++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        {presetn, psel, penable, pwrite, tz, to} = 6'h0;
        paddr = '0;
        pwdata = '0;
        errors = 0;
        n_compared = 0;
        ncell0 = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(OFF_CFG, 32'h3000);
        rd_chk(OFF_STATE, 32'h0);
        rd_chk(OFF_INT_MASK, 32'h0);
        apb(1'b1, 8'h20, 32'hffffffff);
        rd_chk(8'h20, 32'h0);
        chk({31'h0, qerr}, 32'h0);
        for (i = 3; i >= 0; i--) begin
            apb(1'b1, OFF_CFG, 32'(i) << CFG_SIZE_LO);
            rd_chk(OFF_CFG, 32'(i) << CFG_SIZE_LO);
        end
        sched(16'h002f, 14'd5, 14'd5);
        chk(npoll, 32'h2);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, OFF_INT_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rd_chk(OFF_INT_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        sched(16'h0030, 14'd5, 14'd6);
        sched(16'h0031, 14'd2047, 14'd2047);
        sched(16'h0032, 14'd2047, 14'd0);
        serv(14'd6, 1'b1, 16'h0030);
        cell_chk(1, {1'b0, 16'h0030});
        sched(16'h0030, 14'd6, 14'd6);
        serv(14'd6, 1'b1, 16'h0030);
        cell_chk(1, {1'b0, 16'h0030});
        serv(14'd100, 1'b0, 16'h0);
        cell_chk(1, {1'b1, 16'h0});
        apb(1'b1, OFF_CFG, 32'h1);
        serv(14'd5, 1'b1, 16'h002f);
        cell_chk(0, 17'h0);
        pulse(1'b0);
        cell_chk(1, {1'b0, 16'h002f});
        apb(1'b1, OFF_CFG, 32'h3);
        serv(14'd2047, 1'b1, 16'h0031);
        pulse(1'b1);
        cell_chk(1, {1'b0, 16'h0031});
        serv(14'd200, 1'b0, 16'h0);
        cell_chk(0, 17'h0);
        apb(1'b1, OFF_CFG, 32'h0);
        for (i = 0; i < 2048; i++) begin
            apb(1'b1, OFF_SCHED_CM, {16'(i), 2'h0, 14'(i)});
            wait_idle();
        end
        rd_chk(OFF_CFG, 32'h8000);
        apb(1'b1, OFF_CFG, 32'h8000);
        apb(1'b0, OFF_INT_STAT, 32'h0);
        serv(14'd1000, 1'b1, 16'h03e7);
        cell_chk(1, {1'b0, 16'h03e7});
        apb(1'b1, OFF_SCHED_CM, {16'habcd, 16'h0});
        apb(1'b0, OFF_STATE, 32'h0);
        chk(q & 32'h20, 32'h20);
        apb(1'b1, OFF_SCHED_CM, {16'h1234, 16'h0});
        wait_idle();
        rd_chk(OFF_SCHED_AD, 32'h3e8);
        rd_chk(OFF_CFG, 32'h0);
        sched(16'h5555, 14'd0, 14'h3e8);
        rd_chk(OFF_CFG, 32'h8000);
        rd_chk(OFF_INT_STAT, 32'h7);
        tally_and_finish();
    end
endmodule
